/* core/rvrb_top.sv */
// Purpose: Core and port register bank with per-cause reset values.
// Assumes: Power-on is the asynchronous resetn; warm and wake causes come as pulses.
// Notes: Registers at 0x05..0x0F are banked by the bank selector.
`timescale 1ns/1ps
`include "rvrb_cfg.svh"
module rvrb_top
  import rvrb_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic wake_to_vector,
  input wire logic pc_step,
  input wire logic timer_event,
  input wire logic input_change_event,
  input wire logic ext_int_a_event,
  input wire logic ext_int_b_event,
  input wire logic comparator_event,
  output logic [7:0] pc_value,
  output logic [7:0] status_value,
  output logic [7:0] operation_control,
  output logic [1:0] bank_select,
  output logic [7:0] port5_data_out,
  output logic [7:0] port5_dir_out,
  output logic [7:0] port6_data_out,
  output logic [7:0] port6_dir_out,
  output logic [7:0] port7_data_out,
  output logic [7:0] port7_dir_out,
  output logic pin_function_enable,
  output logic port8_bit1,
  output logic [7:0] wakeup_control,
  output logic [7:0] interrupt_pending,
  output logic asleep
);
  rvrb_rst_if rst_bus ();

  rvrb_byte_t bank_selector;
  rvrb_byte_t program_counter_low;
  rvrb_byte_t processor_status;
  rvrb_byte_t indirect_pointer;
  rvrb_byte_t op_ctl;
  rvrb_byte_t port5_data;
  rvrb_byte_t port5_direction;
  rvrb_byte_t port6_data;
  rvrb_byte_t port6_direction;
  rvrb_byte_t port7_data;
  rvrb_byte_t port7_direction;
  rvrb_byte_t port8_and_pin_function;
  rvrb_byte_t wake_ctl;
  rvrb_byte_t pending;
  rvrb_byte_t next_rdata;
  rvrb_byte_t next_wake_ctl;
  rvrb_byte_t next_pending;
  logic [ADDR_W-1:0] target;
  logic warm;
  logic wake;

  rvrb_reset_ctl u_reset_ctl (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ext_reset_req(ext_reset_req),
    .wdt_reset_req(wdt_reset_req),
    .sleep_req(sleep_req),
    .wake_req(wake_req),
    .wake_to_vector(wake_to_vector),
    .bus(rst_bus.ctl)
  );

  assign warm = rst_bus.warm_init;
  assign wake = rst_bus.wake_init;

  // Address through the indirect port goes to the pointer's low nibble
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] a,
                                                  input rvrb_byte_t ptr);
    if (a == ADDR_W'(`RVRB_ADDR_INDIRECT)) eff_addr = {{(ADDR_W-4){1'b0}}, ptr[3:0]};
    else eff_addr = a;
  endfunction : eff_addr

  // Banked registers need the matching bank selector value
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] want,
                               input logic [1:0] bank, input logic [1:0] need);
    hit = (a == ADDR_W'(want)) && (bank == need);
  endfunction : hit

  // Merge write data into the writable bits only
  function automatic rvrb_byte_t merge(input rvrb_byte_t old, input rvrb_byte_t wd,
                                       input rvrb_byte_t mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction : merge

  assign target = eff_addr(reg_addr, indirect_pointer);

  // Bank selector
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) bank_selector <= `RVRB_RST_ZERO;
    else if (warm) bank_selector <= `RVRB_RST_ZERO;
    else if (reg_wr && target == ADDR_W'(`RVRB_ADDR_BANKSEL))
      bank_selector <= merge(bank_selector, reg_wdata, `RVRB_MASK_BANKSEL);
  end

  // Operation control, held on wake-up
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) op_ctl <= `RVRB_RST_ZERO;
    else if (warm) op_ctl <= `RVRB_RST_ZERO;
    else if (reg_wr && target == ADDR_W'(`RVRB_ADDR_OPCTL)) op_ctl <= reg_wdata;
  end

  // Program counter: reset to zero, vector or continue on wake-up
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) program_counter_low <= `RVRB_RST_ZERO;
    else if (warm) program_counter_low <= `RVRB_RST_ZERO;
    else if (wake) begin
      if (rst_bus.wake_vector) program_counter_low <= `RVRB_PC_VECTOR;
    end else if (reg_wr && target == ADDR_W'(`RVRB_ADDR_PC)) program_counter_low <= reg_wdata;
    else if (pc_step && !rst_bus.asleep)
      program_counter_low <= 8'(program_counter_low + 8'h01);
  end

  // Status: time-out and power-down bits follow the reset cause
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) processor_status <= `RVRB_RST_STATUS_POR;
    else if (warm) begin
      processor_status[7:5] <= 3'h0;
      processor_status[`RVRB_BIT_TIMEOUT] <= !rst_bus.warm_is_wdt;
      processor_status[`RVRB_BIT_POWERDOWN] <= !(rst_bus.warm_is_wdt &&
                                                 rst_bus.warm_in_sleep);
    end else if (wake) begin
      processor_status[`RVRB_BIT_TIMEOUT] <= 1'b1;
      processor_status[`RVRB_BIT_POWERDOWN] <= 1'b0;
    end else if (reg_wr && target == ADDR_W'(`RVRB_ADDR_STATUS))
      processor_status <= merge(processor_status, reg_wdata, `RVRB_MASK_STATUS_SW);
  end

  // Indirect pointer: top two bits forced low by resets
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) indirect_pointer <= `RVRB_RST_ZERO;
    else if (warm) indirect_pointer <= indirect_pointer & `RVRB_MASK_POINTER_LOW;
    else if (reg_wr && target == ADDR_W'(`RVRB_ADDR_POINTER)) indirect_pointer <= reg_wdata;
  end

  // Port data: undefined after resets, so warm reset keeps the old value
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port5_data <= `RVRB_RST_ZERO;
      port6_data <= `RVRB_RST_ZERO;
      port7_data <= `RVRB_RST_ZERO;
    end else if (reg_wr && !warm) begin
      if (hit(target, `RVRB_ADDR_PORT5, bank_selector[1:0], `RVRB_BANK_DATA))
        port5_data <= reg_wdata;
      if (hit(target, `RVRB_ADDR_PORT6, bank_selector[1:0], `RVRB_BANK_DATA))
        port6_data <= reg_wdata;
      if (hit(target, `RVRB_ADDR_PORT7, bank_selector[1:0], `RVRB_BANK_DATA))
        port7_data <= merge(port7_data, reg_wdata, `RVRB_MASK_PORT7);
    end
  end

  // Port direction: all inputs after resets
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port5_direction <= `RVRB_RST_DIR;
      port6_direction <= `RVRB_RST_DIR;
      port7_direction <= `RVRB_RST_DIR;
    end else if (warm) begin
      port5_direction <= `RVRB_RST_DIR;
      port6_direction <= `RVRB_RST_DIR;
      port7_direction <= `RVRB_RST_DIR;
    end else if (reg_wr) begin
      if (hit(target, `RVRB_ADDR_PORT5, bank_selector[1:0], `RVRB_BANK_DIR))
        port5_direction <= reg_wdata;
      if (hit(target, `RVRB_ADDR_PORT6, bank_selector[1:0], `RVRB_BANK_DIR))
        port6_direction <= reg_wdata;
      if (hit(target, `RVRB_ADDR_PORT7, bank_selector[1:0], `RVRB_BANK_DIR))
        port7_direction <= merge(port7_direction, reg_wdata, `RVRB_MASK_PORT7);
    end
  end

  // Register 8: pin function bit cleared, port 8 bits kept
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) port8_and_pin_function <= `RVRB_RST_ZERO;
    else if (warm)
      port8_and_pin_function <= port8_and_pin_function & `RVRB_MASK_PORT8_KEEP;
    else if (reg_wr && hit(target, `RVRB_ADDR_PORT8, bank_selector[1:0], `RVRB_BANK_DATA))
      port8_and_pin_function <= merge(port8_and_pin_function, reg_wdata, `RVRB_MASK_PORT8);
  end

  // Wake-up control next value: event flags win over a software clear
  always_comb begin
    next_wake_ctl = wake_ctl;
    if (reg_wr && hit(target, `RVRB_ADDR_WAKECTL, bank_selector[1:0], `RVRB_BANK_DATA))
      next_wake_ctl = merge(wake_ctl, reg_wdata, `RVRB_MASK_WAKECTL);
    if (ext_int_b_event) next_wake_ctl[`RVRB_BIT_EXTB] = 1'b1;
    if (comparator_event) next_wake_ctl[`RVRB_BIT_CMPFLAG] = 1'b1;
  end

  // Wake-up control register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wake_ctl <= `RVRB_RST_ZERO;
    else if (warm) wake_ctl <= `RVRB_RST_ZERO;
    else wake_ctl <= next_wake_ctl;
  end

  // Pending flags next value: event flags win over a software clear
  always_comb begin
    next_pending = pending;
    if (reg_wr && hit(target, `RVRB_ADDR_PENDING, bank_selector[1:0], `RVRB_BANK_DATA))
      next_pending = merge(pending, reg_wdata, `RVRB_MASK_PENDING);
    if (timer_event) next_pending[`RVRB_BIT_TIMER] = 1'b1;
    if (input_change_event) next_pending[`RVRB_BIT_ICHANGE] = 1'b1;
    if (ext_int_a_event) next_pending[`RVRB_BIT_EXTA] = 1'b1;
  end

  // Pending flags register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) pending <= `RVRB_RST_ZERO;
    else if (warm) pending <= `RVRB_RST_ZERO;
    else pending <= next_pending;
  end

  // Read multiplexer; unmapped, reserved and other banks read zero
  always_comb begin
    next_rdata = `RVRB_RST_ZERO;
    unique case (target)
      ADDR_W'(`RVRB_ADDR_BANKSEL): next_rdata = bank_selector;
      ADDR_W'(`RVRB_ADDR_PC): next_rdata = program_counter_low;
      ADDR_W'(`RVRB_ADDR_STATUS): next_rdata = processor_status;
      ADDR_W'(`RVRB_ADDR_POINTER): next_rdata = indirect_pointer;
      ADDR_W'(`RVRB_ADDR_OPCTL): next_rdata = op_ctl;
      default: next_rdata = `RVRB_RST_ZERO;
    endcase
    if (bank_selector[1:0] == `RVRB_BANK_DATA) begin
      if (target == ADDR_W'(`RVRB_ADDR_PORT5)) next_rdata = port5_data;
      if (target == ADDR_W'(`RVRB_ADDR_PORT6)) next_rdata = port6_data;
      if (target == ADDR_W'(`RVRB_ADDR_PORT7)) next_rdata = port7_data;
      if (target == ADDR_W'(`RVRB_ADDR_PORT8)) next_rdata = port8_and_pin_function;
      if (target == ADDR_W'(`RVRB_ADDR_WAKECTL)) next_rdata = wake_ctl;
      if (target == ADDR_W'(`RVRB_ADDR_PENDING)) next_rdata = pending;
    end else if (bank_selector[1:0] == `RVRB_BANK_DIR) begin
      if (target == ADDR_W'(`RVRB_ADDR_PORT5)) next_rdata = port5_direction;
      if (target == ADDR_W'(`RVRB_ADDR_PORT6)) next_rdata = port6_direction;
      if (target == ADDR_W'(`RVRB_ADDR_PORT7)) next_rdata = port7_direction;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) reg_rdata <= `RVRB_RST_ZERO;
    else if (reg_rd) reg_rdata <= next_rdata;
    else reg_rdata <= `RVRB_RST_ZERO;
  end

  // Register contents driven out to the core and ports
  assign pc_value = program_counter_low;
  assign status_value = processor_status;
  assign operation_control = op_ctl;
  assign bank_select = bank_selector[1:0];
  assign port5_data_out = port5_data;
  assign port5_dir_out = port5_direction;
  assign port6_data_out = port6_data;
  assign port6_dir_out = port6_direction;
  assign port7_data_out = port7_data;
  assign port7_dir_out = port7_direction;
  assign pin_function_enable = port8_and_pin_function[`RVRB_BIT_PINFUNC];
  assign port8_bit1 = port8_and_pin_function[1];
  assign wakeup_control = wake_ctl;
  assign interrupt_pending = pending;
  assign asleep = rst_bus.asleep;
endmodule : rvrb_top

/* core/rvrb_cfg.svh */
// Purpose: Constants of the reset-value register bank: offsets, masks, reset values.
// Assumes: Byte-wide registers reached by a 5-bit register address.
// Notes: Reset causes are power-on, warm reset and pin-change wake-up.
// Function
// - Operation control clears on power-on and warm reset, holds on wake-up.
// - Bank selector, both bank bits, clears on power-on and warm reset, holds on wake.
// - Program counter goes to zero on power-on and warm reset.
// - Wake-up jumps to vector 0x08 or continues with the next instruction.
// - Power-on sets time-out and power-down bits; warm resets show the cause.
// - Port 5, 6, 7 data undefined after resets, held on wake-up.
// - Port 5, 6, 7 direction bits set to one on resets, held on wake.
// - Wake-up control clears on resets, held on wake-up.
// - Register 8 clears pin-function and upper bits on resets; port 8 bit kept.
`ifndef RVRB_CFG_SVH
`define RVRB_CFG_SVH

// Register addresses
`define RVRB_ADDR_INDIRECT 5'h00
`define RVRB_ADDR_BANKSEL 5'h01
`define RVRB_ADDR_PC 5'h02
`define RVRB_ADDR_STATUS 5'h03
`define RVRB_ADDR_POINTER 5'h04
`define RVRB_ADDR_PORT5 5'h05
`define RVRB_ADDR_PORT6 5'h06
`define RVRB_ADDR_PORT7 5'h07
`define RVRB_ADDR_PORT8 5'h08
`define RVRB_ADDR_WAKECTL 5'h0E
`define RVRB_ADDR_PENDING 5'h0F
`define RVRB_ADDR_OPCTL 5'h10

// Bank selector values for the banked range
`define RVRB_BANK_DATA 2'h0
`define RVRB_BANK_DIR 2'h1

// Writable bit masks and warm-reset keep masks
`define RVRB_MASK_BANKSEL 8'h03
`define RVRB_MASK_STATUS_SW 8'hE7
`define RVRB_MASK_POINTER_LOW 8'h3F
`define RVRB_MASK_PORT7 8'h8F
`define RVRB_MASK_PORT8 8'h22
`define RVRB_MASK_PORT8_KEEP 8'h03
`define RVRB_MASK_WAKECTL 8'h95
`define RVRB_MASK_PENDING 8'h07

// Field positions
`define RVRB_BIT_TIMEOUT 4
`define RVRB_BIT_POWERDOWN 3
`define RVRB_BIT_PINFUNC 5
`define RVRB_BIT_EXTB 7
`define RVRB_BIT_ICWAKE 4
`define RVRB_BIT_CMPWAKE 2
`define RVRB_BIT_CMPFLAG 0
`define RVRB_BIT_TIMER 0
`define RVRB_BIT_ICHANGE 1
`define RVRB_BIT_EXTA 2

// Reset values
`define RVRB_RST_ZERO 8'h00
`define RVRB_RST_DIR 8'hFF
`define RVRB_RST_STATUS_POR 8'h18
`define RVRB_PC_VECTOR 8'h08

`endif

/* core/rvrb_pkg.sv */
// Purpose: Types shared by the register bank modules.
// Assumes: Nothing beyond the constants header.
// Notes: Sequencer states are one-hot.
package rvrb_pkg;
  typedef enum logic [2:0] {
    RVRB_RUN = 3'b001,
    RVRB_SLEEP = 3'b010,
    RVRB_WARM = 3'b100
  } rvrb_state_t;
  typedef logic [7:0] rvrb_byte_t;
endpackage : rvrb_pkg

/* core/rvrb_rst_if.sv */
// Purpose: Reset-cause signals from the sequencer to the register bank.
// Assumes: One clock domain.
// Notes: Warm and wake pulses last one cycle; asleep is a level held while asleep, warm_in_sleep is that level one cycle later.
`timescale 1ns/1ps
interface rvrb_rst_if;
  logic warm_init;
  logic warm_is_wdt;
  logic warm_in_sleep;
  logic wake_init;
  logic wake_vector;
  logic asleep;
  modport ctl (output warm_init, warm_is_wdt, warm_in_sleep, wake_init, wake_vector, asleep);
  modport bank (input warm_init, warm_is_wdt, warm_in_sleep, wake_init, wake_vector, asleep);
endinterface : rvrb_rst_if

/* core/rvrb_reset_ctl.sv */
// Purpose: Sequencer that turns reset and wake requests into cause pulses.
// Assumes: Requests are one-cycle pulses synchronous to sys_clk.
// Notes: Warm reset beats wake-up when both arrive together.
`timescale 1ns/1ps
`include "rvrb_cfg.svh"
module rvrb_reset_ctl
  import rvrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic wake_to_vector,
  rvrb_rst_if.ctl bus
);
  rvrb_state_t state;
  rvrb_state_t next_state;
  logic warm_any;
  logic wdt_seen;
  logic sleep_seen;
  logic wake_seen;
  logic vector_seen;

  assign warm_any = ext_reset_req | wdt_reset_req;

  // Next state: sleep until wake, warm reset from run or sleep
  always_comb begin
    next_state = state;
    unique case (state)
      RVRB_RUN: begin
        if (warm_any) next_state = RVRB_WARM;
        else if (sleep_req) next_state = RVRB_SLEEP;
      end
      RVRB_SLEEP: begin
        if (warm_any) next_state = RVRB_WARM;
        else if (wake_req) next_state = RVRB_RUN;
      end
      RVRB_WARM: next_state = RVRB_RUN;
      default: next_state = RVRB_RUN;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) state <= RVRB_RUN;
    else state <= next_state;
  end

  // Capture the cause of each transition for the bank
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wdt_seen <= 1'b0;
      sleep_seen <= 1'b0;
      wake_seen <= 1'b0;
      vector_seen <= 1'b0;
    end else begin
      wdt_seen <= wdt_reset_req;
      sleep_seen <= (state == RVRB_SLEEP);
      wake_seen <= (state == RVRB_SLEEP) && !warm_any && wake_req;
      vector_seen <= wake_to_vector;
    end
  end

  assign bus.warm_init = (state == RVRB_WARM);
  assign bus.warm_is_wdt = wdt_seen;
  assign bus.warm_in_sleep = sleep_seen;
  assign bus.wake_init = wake_seen;
  assign bus.wake_vector = vector_seen;
  assign bus.asleep = (state == RVRB_SLEEP);
endmodule : rvrb_reset_ctl

/* sim/rvrb_monitor.sv */
// Purpose: Port-level checks on the register bank's reset and wake behaviour.
// Assumes: Warm and wake requests are one-cycle pulses.
// Notes: Checks stand aside while a warm request is still in flight.
`timescale 1ns/1ps
module rvrb_monitor #(
  parameter int ADDR_W = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic wake_req,
  input wire logic wake_to_vector,
  input wire logic pc_step,
  input wire logic timer_event,
  input wire logic [7:0] pc_value,
  input wire logic [7:0] status_value,
  input wire logic [7:0] operation_control,
  input wire logic [1:0] bank_select,
  input wire logic [7:0] port5_dir_out,
  input wire logic [7:0] port7_dir_out,
  input wire logic [7:0] interrupt_pending,
  input wire logic asleep
);
  logic [1:0] req_hist;
  logic warm;
  logic quiet;
  // Warm requests of the last two cycles
  assign warm = ext_reset_req | wdt_reset_req;
  assign quiet = !warm && req_hist == 2'h0;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_hist <= 2'h0;
    end else begin
      req_hist <= {req_hist[0], warm};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Warm request followed by two cycles with no write or step
  sequence s_warm(r);
    r && req_hist == 2'h0 ##1 !(reg_wr || pc_step) [*2];
  endsequence
  sequence s_wake;
    asleep && wake_req && quiet;
  endsequence
  property p_warm_ext;
    s_warm(ext_reset_req && !wdt_reset_req) |=> operation_control == 8'h00
      && pc_value == 8'h00 && bank_select == 2'h0 && status_value[7:3] == 5'h03;
  endproperty
  a_warm_ext: assert property (p_warm_ext)
    else $error("warm reset values wrong");
  property p_warm_dir;
    s_warm(warm) |=> port5_dir_out == 8'hFF && port7_dir_out == 8'hFF;
  endproperty
  a_warm_dir: assert property (p_warm_dir)
    else $error("direction not all ones after warm reset");
  property p_warm_wdt;
    s_warm(wdt_reset_req && !ext_reset_req && !asleep) |=> status_value[4:3] == 2'h1;
  endproperty
  a_warm_wdt: assert property (p_warm_wdt)
    else $error("watchdog cause bits wrong");
  property p_wake_leave;
    s_wake |=> !asleep;
  endproperty
  a_wake_leave: assert property (p_wake_leave)
    else $error("still asleep after wake");
  property p_wake_vec;
    s_wake ##0 wake_to_vector ##1 !(reg_wr || pc_step) |=> pc_value == 8'h08
      && status_value[4:3] == 2'h2;
  endproperty
  a_wake_vec: assert property (p_wake_vec)
    else $error("wake to vector wrong");
  property p_wake_keep;
    s_wake ##1 !reg_wr |=> operation_control == $past(operation_control, 2)
      && bank_select == $past(bank_select, 2);
  endproperty
  a_wake_keep: assert property (p_wake_keep)
    else $error("register lost over wake");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_bank_wr;
    reg_wr && reg_addr == ADDR_W'(1) && quiet |=> bank_select == $past(reg_wdata[1:0]);
  endproperty
  a_bank_wr: assert property (p_bank_wr)
    else $error("bank write lost");
  property p_pc_step;
    pc_step && !asleep && !$past(asleep) && !reg_wr && quiet
      |=> pc_value == 8'($past(pc_value) + 8'h01);
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter step wrong");
  property p_timer;
    timer_event && req_hist == 2'h0 |=> interrupt_pending[0];
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer flag not set");
endmodule : rvrb_monitor

/* sim/tb.sv */
// Purpose: Self-checking bench for the reset-value register bank.
// Assumes: Register bus with read data one cycle after the strobe.
// Notes: Checks are made at the falling edge, after updates settle.
`timescale 1ns/1ps
module tb;
  localparam logic [10:0] EXT = 11'h001, WDT = 11'h002, SLP = 11'h004, WK = 11'h008;
  localparam logic [10:0] VEC = 11'h010, EVS = 11'h3E0, TMR = 11'h020, STP = 11'h400;
  logic sys_clk, resetn, reg_wr, reg_rd, pin_function_enable, port8_bit1, asleep;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pc_value, status_value, operation_control;
  logic [7:0] port5_data_out, port5_dir_out, port6_data_out, port6_dir_out;
  logic [7:0] port7_data_out, port7_dir_out, wakeup_control, interrupt_pending;
  logic [1:0] bank_select;
  logic [10:0] req;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  rvrb_top #(.ADDR_W(5)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_reset_req(req[0]), .wdt_reset_req(req[1]), .sleep_req(req[2]), .wake_req(req[3]),
    .wake_to_vector(req[4]), .timer_event(req[5]), .input_change_event(req[6]),
    .ext_int_a_event(req[7]), .ext_int_b_event(req[8]), .comparator_event(req[9]),
    .pc_step(req[10]), .pc_value(pc_value), .status_value(status_value),
    .operation_control(operation_control), .bank_select(bank_select),
    .port5_data_out(port5_data_out), .port5_dir_out(port5_dir_out),
    .port6_data_out(port6_data_out), .port6_dir_out(port6_dir_out),
    .port7_data_out(port7_data_out), .port7_dir_out(port7_dir_out),
    .pin_function_enable(pin_function_enable), .port8_bit1(port8_bit1),
    .wakeup_control(wakeup_control), .interrupt_pending(interrupt_pending), .asleep(asleep));
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rchk
  // One-cycle request, then n more edges before looking
  task pulse(input logic [10:0] m, input int n);
    @(posedge sys_clk);
    req <= m;
    @(posedge sys_clk);
    req <= 11'h000;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : pulse
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req = 11'h000;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk({status_value, pc_value}, 16'h1800);
    chk({operation_control, interrupt_pending}, 16'h0000);
    chk({wakeup_control, 6'h00, bank_select}, 16'h0000);
    chk({port5_dir_out, port6_dir_out}, 16'hFFFF);
    chk({port7_dir_out, 7'h00, pin_function_enable}, 16'hFF00);
    // Load non-reset values, then read them back
    wr(5'h10, 8'h5A);
    wr(5'h04, 8'hFF);
    wr(5'h05, 8'hAA);
    wr(5'h07, 8'hFF);
    wr(5'h08, 8'hFF);
    wr(5'h0E, 8'hFF);
    wr(5'h0F, 8'hFF);
    wr(5'h03, 8'h07);
    wr(5'h0B, 8'hFF);
    rchk(5'h07, 8'h8F);
    rchk(5'h08, 8'h22);
    rchk(5'h0E, 8'h95);
    rchk(5'h03, 8'h1F);
    rchk(5'h04, 8'hFF);
    rchk(5'h00, 8'h07);
    rchk(5'h0B, 8'h00);
    rchk(5'h1F, 8'h00);
    rchk(5'h10, 8'h5A);
    wr(5'h01, 8'h01);
    wr(5'h05, 8'h0F);
    wr(5'h07, 8'h00);
    rchk(5'h07, 8'h70);
    repeat (3) pulse(STP, 0);
    chk({8'h00, pc_value}, 16'h0003);
    // External reset from run
    pulse(EXT, 2);
    chk({operation_control, status_value}, 16'h001F);
    chk({pc_value, 6'h00, bank_select}, 16'h0000);
    chk({port5_dir_out, port7_dir_out}, 16'hFFFF);
    chk({port5_data_out, wakeup_control}, 16'hAA00);
    chk({interrupt_pending, 6'h00, pin_function_enable, port8_bit1}, 16'h0001);
    chk({port6_data_out, port7_data_out}, 16'h008F);
    rchk(5'h04, 8'h3F);
    pulse(EVS, 0);
    chk({interrupt_pending, wakeup_control}, 16'h0781);
    // Watchdog reset from run
    pulse(WDT, 2);
    chk({wakeup_control, status_value}, 16'h000F);
    chk({8'h00, interrupt_pending}, 16'h0000);
    // Sleep, then wake to the vector
    wr(5'h10, 8'h3C);
    wr(5'h01, 8'h01);
    wr(5'h05, 8'h0F);
    pulse(TMR, 0);
    pulse(SLP, 0);
    chk({15'h0000, asleep}, 16'h0001);
    pulse(WK | VEC, 1);
    chk({pc_value, status_value}, 16'h0817);
    chk({operation_control, port5_dir_out}, 16'h3C0F);
    chk({interrupt_pending, 6'h00, bank_select}, 16'h0101);
    // Wake that continues, then watchdog while asleep
    pulse(STP, 0);
    pulse(SLP, 0);
    pulse(WK, 1);
    chk({pc_value, 7'h00, asleep}, 16'h0900);
    pulse(SLP, 0);
    pulse(WDT, 2);
    chk({pc_value, status_value}, 16'h0007);
    chk({operation_control, port5_dir_out}, 16'h00FF);
    give_verdict();
  end
endmodule : tb
bind rvrb_top rvrb_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk(sys_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_reset_req(ext_reset_req), .wdt_reset_req(wdt_reset_req),
  .wake_req(wake_req), .wake_to_vector(wake_to_vector), .pc_step(pc_step),
  .timer_event(timer_event), .pc_value(pc_value), .status_value(status_value),
  .operation_control(operation_control), .bank_select(bank_select),
  .port5_dir_out(port5_dir_out), .port7_dir_out(port7_dir_out),
  .interrupt_pending(interrupt_pending), .asleep(asleep));
